// >>> pkg/csie_pkg.sv
// Package of constants and types for the processor status and interrupt enable block.
package csie_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_GLOBAL_IRQ_MASK   = 8'h20;
   localparam logic [7:0] ADDR_ENDPOINT_IRQ_MASK = 8'h21;
   localparam logic [7:0] ADDR_PROC_STATE_CTRL   = 8'hFF;
   // ==========================================================
   // Field positions and source count
   localparam int BIT_RUN       = 0;
   localparam int BIT_IRQ_SENSE = 2;
   localparam int BIT_SUSPEND   = 3;
   localparam int BIT_POR       = 4;
   localparam int BIT_BUS_RST   = 5;
   localparam int BIT_WDOG      = 6;
   localparam int BIT_PENDING   = 7;
   localparam int NUM_SRC       = 11;
   // ==========================================================
   // Reset values and write masks
   localparam logic [7:0] RST_PROC_STATE_CTRL = 8'h11;
   localparam logic [7:0] RST_GLOBAL_MASK     = 8'h00;
   localparam logic [7:0] RST_ENDPOINT_MASK   = 8'h00;
   localparam logic [7:0] GLOBAL_MASK_BITS    = 8'h6F;
   localparam logic [7:0] ENDPOINT_MASK_BITS  = 8'h1F;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ        = 100;
   localparam int SE0_MIN_US     = 12;
   localparam int SE0_CYCLES     = SE0_MIN_US * CLK_MHZ;
   localparam int TICK_128_US    = 128;
   localparam int TICK_128_CYC   = TICK_128_US * CLK_MHZ;
   localparam int TICK_1024_US   = 1024;
   localparam int TICK_1024_CYC  = TICK_1024_US * CLK_MHZ;
   localparam int WDOG_MS        = 8;
   localparam int WDOG_CYC       = WDOG_MS * 1000 * CLK_MHZ;
   localparam int STARTUP_MS     = 96;
   localparam int STARTUP_CYC    = STARTUP_MS * 1000 * CLK_MHZ;
   // ==========================================================
   // Core states
   typedef enum logic [1:0] {CSIE_RUNNING, CSIE_SUSPENDED, CSIE_HALTED} csie_core_state_t;
endpackage : csie_pkg

// >>> pkg/csie_irq_if.sv
// Interface carrying interrupt requests and masks between the control block and its arbiter.
interface csie_irq_if;
   logic [10:0] raw;
   logic [10:0] mask;
   logic        sense;
   logic        take;
   logic        pending;
   logic        wake;
   logic [3:0]  vector;
   modport ctrl (output raw, output mask, output sense, output take, input pending, input wake, input vector);
   modport arb  (input raw, input mask, input sense, input take, output pending, output wake, output vector);
endinterface : csie_irq_if

// >>> rtl/csie_irq_arb.sv
// Interrupt latch and priority arbiter.
module csie_irq_arb
   import csie_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   csie_irq_if.arb   irq
);
   logic [NUM_SRC-1:0] latched;
   logic [NUM_SRC-1:0] ready;
   logic [NUM_SRC-1:0] take_bit;
   logic [3:0]         next_vector;

   assign ready = latched & irq.mask;

   // ==========================================================
   // Highest priority is the lowest index.
   always_comb
   begin
      next_vector = 4'hF;
      take_bit    = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (ready[i])
         begin
            next_vector = 4'(i);
            take_bit    = '0;
            take_bit[i] = 1'b1;
         end
      end
   end

   // ==========================================================
   // Latch each event; a new event wins over its own clear.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latched <= '0;
      end
      else
      begin
         latched <= (latched & ~(irq.take && irq.sense ? take_bit : '0)) | irq.raw;
      end
   end

   assign irq.pending = |latched;
   assign irq.wake    = |ready;
   assign irq.vector  = next_vector;
endmodule : csie_irq_arb

// >>> rtl/csie_ctrl.sv
// Processor status and control register with global and endpoint interrupt enables.
module csie_ctrl
   import csie_pkg::*;
#(
   parameter int SE0_CYC_P     = SE0_CYCLES,
   parameter int T128_CYC_P    = TICK_128_CYC,
   parameter int T1024_CYC_P   = TICK_1024_CYC,
   parameter int WDOG_CYC_P    = WDOG_CYC,
   parameter int STARTUP_CYC_P = STARTUP_CYC
)
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] io_addr_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic       port_write_instr_i,
   input  wire logic       io_read_i,
   output logic      [7:0] io_rdata_o,
   input  wire logic       halt_instr_i,
   input  wire logic       enable_irq_instr_i,
   input  wire logic       disable_irq_instr_i,
   input  wire logic       return_from_irq_instr_i,
   input  wire logic       irq_enter_i,
   input  wire logic       watchdog_clear_i,
   input  wire logic       usb_dp_i,
   input  wire logic       usb_dm_i,
   input  wire logic       usb_activity_i,
   input  wire logic       hub_irq_i,
   input  wire logic       gpio_irq_i,
   input  wire logic       serial_irq_i,
   input  wire logic [4:0] endpoint_irq_i,
   output logic            cpu_run_o,
   output logic            suspended_o,
   output logic            irq_pending_o,
   output logic      [3:0] irq_vector_o,
   output logic            watchdog_reset_flag_o
);
   csie_irq_if irq ();

   csie_core_state_t state;
   logic [7:0]  proc_flags;
   logic [7:0]  global_irq_mask;
   logic [7:0]  endpoint_irq_mask;
   logic        irq_sense;
   logic [2:0]  sync_dp;
   logic [2:0]  sync_dm;
   logic [2:0]  sync_act;
   logic        se0;
   logic        act;
   logic [31:0] se0_cnt;
   logic        se0_seen;
   logic        bus_reset_evt;
   logic        bus_reset_end;
   logic [31:0] t128_cnt;
   logic [31:0] t1024_cnt;
   logic        t128_evt;
   logic        t1024_evt;
   logic [31:0] wdog_cnt;
   logic        wdog_fire;
   logic        startup;
   logic [31:0] startup_cnt;
   logic        wr_ctrl;
   logic        wr_global;
   logic        wr_endpoint;
   logic        suspend_req;

   function automatic logic agreed(input logic [2:0] s, input logic prev);
      agreed = (s[1] == s[2]) ? s[2] : prev;
   endfunction : agreed

   assign wr_ctrl     = port_write_instr_i && io_addr_i == ADDR_PROC_STATE_CTRL;
   assign wr_global   = port_write_instr_i && io_addr_i == ADDR_GLOBAL_IRQ_MASK;
   assign wr_endpoint = port_write_instr_i && io_addr_i == ADDR_ENDPOINT_IRQ_MASK;
   assign suspend_req = wr_ctrl && io_wdata_i[BIT_SUSPEND] && !act;

   // ==========================================================
   // Pin synchronisers; stage 0 feeds only stage 1.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync_dp  <= 3'h7;
         sync_dm  <= 3'h0;
         sync_act <= 3'h0;
         se0      <= 1'b0;
         act      <= 1'b0;
      end
      else
      begin
         sync_dp  <= {sync_dp[1:0], usb_dp_i};
         sync_dm  <= {sync_dm[1:0], usb_dm_i};
         sync_act <= {sync_act[1:0], usb_activity_i};
         se0      <= (sync_dp[1] == sync_dp[2] && sync_dm[1] == sync_dm[2]) ? !sync_dp[2] && !sync_dm[2] : se0;
         act      <= agreed(sync_act, act);
      end
   end

   // ==========================================================
   // Bus reset detection.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         se0_cnt       <= '0;
         se0_seen      <= 1'b0;
         bus_reset_evt <= 1'b0;
         bus_reset_end <= 1'b0;
      end
      else
      begin
         bus_reset_evt <= 1'b0;
         bus_reset_end <= 1'b0;
         if (se0)
         begin
            if (se0_cnt < 32'(SE0_CYC_P))
            begin
               se0_cnt <= se0_cnt + 32'h1;
            end
            else if (!se0_seen)
            begin
               se0_seen      <= 1'b1;
               bus_reset_evt <= 1'b1;
            end
         end
         else
         begin
            se0_cnt       <= '0;
            se0_seen      <= 1'b0;
            bus_reset_end <= se0_seen;
         end
      end
   end

   // ==========================================================
   // Periodic timers.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         t128_cnt  <= '0;
         t1024_cnt <= '0;
         t128_evt  <= 1'b0;
         t1024_evt <= 1'b0;
      end
      else
      begin
         t128_evt  <= t128_cnt == 32'(T128_CYC_P - 1);
         t1024_evt <= t1024_cnt == 32'(T1024_CYC_P - 1);
         t128_cnt  <= (t128_cnt == 32'(T128_CYC_P - 1)) ? '0 : t128_cnt + 32'h1;
         t1024_cnt <= (t1024_cnt == 32'(T1024_CYC_P - 1)) ? '0 : t1024_cnt + 32'h1;
      end
   end

   // ==========================================================
   // Watchdog and start-up suspend.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wdog_cnt    <= '0;
         wdog_fire   <= 1'b0;
         startup     <= 1'b1;
         startup_cnt <= '0;
      end
      else
      begin
         wdog_fire <= 1'b0;
         if (watchdog_clear_i || wdog_fire)
         begin
            wdog_cnt <= '0;
         end
         else if (wdog_cnt == 32'(WDOG_CYC_P - 1))
         begin
            wdog_fire <= 1'b1;
            wdog_cnt  <= '0;
         end
         else
         begin
            wdog_cnt <= wdog_cnt + 32'h1;
         end
         if (startup)
         begin
            startup_cnt <= startup_cnt + 32'h1;
            if (se0 || startup_cnt == 32'(STARTUP_CYC_P - 1))
            begin
               startup <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Core run state.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state <= CSIE_RUNNING;
      end
      else
      begin
         unique case (state)
            CSIE_RUNNING:
            begin
               if (halt_instr_i)
               begin
                  state <= CSIE_HALTED;
               end
               else if (suspend_req)
               begin
                  state <= CSIE_SUSPENDED;
               end
            end
            CSIE_SUSPENDED:
            begin
               if (wdog_fire)
               begin
                  state <= CSIE_RUNNING;
               end
               else if (irq.wake || act)
               begin
                  state <= CSIE_RUNNING;
               end
            end
            CSIE_HALTED:
            begin
               if (wdog_fire)
               begin
                  state <= CSIE_RUNNING;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Processor status and control flags.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         proc_flags <= RST_PROC_STATE_CTRL;
      end
      else if (wdog_fire)
      begin
         proc_flags[BIT_WDOG]    <= 1'b1;
         proc_flags[BIT_RUN]     <= 1'b1;
         proc_flags[BIT_SUSPEND] <= 1'b0;
         proc_flags[1]           <= 1'b0;
      end
      else if (halt_instr_i)
      begin
         proc_flags <= 8'(bus_reset_evt) << BIT_BUS_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            proc_flags[BIT_RUN]  <= io_wdata_i[BIT_RUN];
            proc_flags[1]        <= io_wdata_i[1];
            proc_flags[BIT_POR]  <= io_wdata_i[BIT_POR];
            proc_flags[BIT_WDOG] <= io_wdata_i[BIT_WDOG];
         end
         proc_flags[BIT_SUSPEND] <= suspend_req ? 1'b1 : (state == CSIE_SUSPENDED && !(irq.wake || act))
                                    ? proc_flags[BIT_SUSPEND] : 1'b0;
         if (bus_reset_evt)
         begin
            proc_flags[BIT_BUS_RST] <= 1'b1;
         end
         else if (wr_ctrl)
         begin
            proc_flags[BIT_BUS_RST] <= io_wdata_i[BIT_BUS_RST];
         end
      end
   end

   // ==========================================================
   // Global interrupt sense.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_sense <= 1'b0;
      end
      else if (wdog_fire || halt_instr_i || disable_irq_instr_i || irq_enter_i)
      begin
         irq_sense <= 1'b0;
      end
      else if (enable_irq_instr_i || return_from_irq_instr_i)
      begin
         irq_sense <= 1'b1;
      end
   end

   // ==========================================================
   // Enable masks.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         global_irq_mask   <= RST_GLOBAL_MASK;
         endpoint_irq_mask <= RST_ENDPOINT_MASK;
      end
      else if (wdog_fire)
      begin
         global_irq_mask   <= RST_GLOBAL_MASK;
         endpoint_irq_mask <= RST_ENDPOINT_MASK;
      end
      else
      begin
         if (wr_global)
         begin
            global_irq_mask <= io_wdata_i & GLOBAL_MASK_BITS;
         end
         if (wr_endpoint)
         begin
            endpoint_irq_mask <= io_wdata_i & ENDPOINT_MASK_BITS;
         end
      end
   end

   // ==========================================================
   // Interrupt sources and masks toward the arbiter.
   assign irq.raw   = {endpoint_irq_i, serial_irq_i, gpio_irq_i, hub_irq_i, t1024_evt, t128_evt, bus_reset_end};
   assign irq.mask  = {endpoint_irq_mask[4:0], global_irq_mask[6:5], global_irq_mask[3:0]};
   assign irq.sense = irq_sense;
   assign irq.take  = irq_enter_i;

   csie_irq_arb u_arb
   (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .irq        (irq)
   );

   // ==========================================================
   // Read port and registered outputs.
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         io_rdata_o            <= 8'h00;
         cpu_run_o             <= 1'b1;
         suspended_o           <= 1'b0;
         irq_pending_o         <= 1'b0;
         irq_vector_o          <= 4'hF;
         watchdog_reset_flag_o <= 1'b0;
      end
      else
      begin
         io_rdata_o <= 8'h00;
         if (io_read_i)
         begin
            unique case (io_addr_i)
               ADDR_PROC_STATE_CTRL:   io_rdata_o <= {irq.pending, proc_flags[6:3], irq_sense, proc_flags[1:0]};
               ADDR_GLOBAL_IRQ_MASK:   io_rdata_o <= global_irq_mask;
               ADDR_ENDPOINT_IRQ_MASK: io_rdata_o <= endpoint_irq_mask;
               default:                io_rdata_o <= 8'h00;
            endcase
         end
         cpu_run_o             <= state == CSIE_RUNNING && !startup && proc_flags[BIT_RUN];
         suspended_o           <= state == CSIE_SUSPENDED || startup;
         irq_pending_o         <= irq.pending && irq_sense && irq.wake;
         irq_vector_o          <= irq.vector;
         watchdog_reset_flag_o <= proc_flags[BIT_WDOG];
      end
   end
endmodule : csie_ctrl

// >>> test/csie_ctrl_properties.sv
// Concurrent checks on the ports of the processor status and interrupt enable block.
module csie_ctrl_properties
   import csie_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       reset_i,
   input wire logic [7:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic       port_write_instr_i,
   input wire logic       io_read_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic       halt_instr_i,
   input wire logic       disable_irq_instr_i,
   input wire logic       irq_enter_i,
   input wire logic       usb_activity_i,
   input wire logic       cpu_run_o,
   input wire logic       suspended_o,
   input wire logic       irq_pending_o,
   input wire logic [3:0] irq_vector_o,
   input wire logic       watchdog_reset_flag_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import csie_pkg::*;
   // ==========================================================
   // Clock and reset for every property.
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence wsus;
      port_write_instr_i && io_addr_i == ADDR_PROC_STATE_CTRL && io_wdata_i[BIT_SUSPEND];
   endsequence

   // ==========================================================
   // Assertions and cover points.
   AST_HALT_STOPS: assert property (halt_instr_i |-> ##[1:3] !cpu_run_o)
      else $error("Run stayed high after halt.");
   AST_HALT_CLEARS: assert property (halt_instr_i ##2 (io_read_i && io_addr_i == ADDR_PROC_STATE_CTRL)
      |=> io_rdata_o[6:0] == 7'h00) else $error("Control bits not cleared by halt.");
   AST_HALT_STAYS: assert property ($past(cpu_run_o) == 1'b0 && $past(suspended_o) == 1'b0
      && !cpu_run_o && !suspended_o |=> !cpu_run_o or (##[0:1] watchdog_reset_flag_o))
      else $error("Halted core restarted without watchdog.");
   AST_SUSP_REFUSED: assert property (usb_activity_i[*5] ##0 wsus ##0 !suspended_o
      |=> (!suspended_o)[*4]) else $error("Suspend taken while bus active.");
   AST_SUSP_WAKE: assert property (suspended_o && $rose(usb_activity_i) ##1 usb_activity_i[*7]
      |=> !suspended_o) else $error("Bus activity did not wake suspend.");
   AST_GMASK_RSVD: assert property (io_read_i && io_addr_i == ADDR_GLOBAL_IRQ_MASK
      |=> (io_rdata_o & ~GLOBAL_MASK_BITS) == 8'h00) else $error("Reserved global bit read set.");
   AST_EPMASK_RSVD: assert property (io_read_i && io_addr_i == ADDR_ENDPOINT_IRQ_MASK
      |=> io_rdata_o[7:5] == 3'h0) else $error("Reserved endpoint bit read set.");
   AST_ENTER_CLEARS: assert property (irq_enter_i && irq_pending_o |-> ##[1:2] !irq_pending_o)
      else $error("Entry did not clear pending.");
   AST_DI_MASKS: assert property (disable_irq_instr_i |-> ##[1:2] !irq_pending_o)
      else $error("Pending shown while disabled.");

   COV_SUSPEND: cover property ($rose(suspended_o));
   COV_HUB: cover property (irq_pending_o && irq_vector_o == 4'h3);
   COV_WDOG: cover property ($rose(watchdog_reset_flag_o));
endmodule : csie_ctrl_properties

bind csie_ctrl csie_ctrl_properties i_props
(
   .core_clk_i (core_clk_i), .reset_i (reset_i), .io_addr_i (io_addr_i), .io_wdata_i (io_wdata_i),
   .port_write_instr_i (port_write_instr_i), .io_read_i (io_read_i), .io_rdata_o (io_rdata_o),
   .halt_instr_i (halt_instr_i), .disable_irq_instr_i (disable_irq_instr_i), .irq_enter_i (irq_enter_i),
   .usb_activity_i (usb_activity_i), .cpu_run_o (cpu_run_o), .suspended_o (suspended_o),
   .irq_pending_o (irq_pending_o), .irq_vector_o (irq_vector_o), .watchdog_reset_flag_o (watchdog_reset_flag_o)
);

// >>> test/csie_ctrl_bench.sv
// Self-checking bench for the processor status and interrupt enable block.
module csie_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import csie_pkg::*;
   logic       core_clk_i, reset_i, port_write_instr_i, io_read_i, halt_instr_i, enable_irq_instr_i;
   logic       disable_irq_instr_i, return_from_irq_instr_i, irq_enter_i, watchdog_clear_i, usb_dp_i;
   logic       usb_dm_i, usb_activity_i, hub_irq_i, gpio_irq_i, serial_irq_i;
   logic       cpu_run_o, suspended_o, irq_pending_o, watchdog_reset_flag_o;
   logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, rd;
   logic [4:0] endpoint_irq_i;
   logic [3:0] irq_vector_o;
   int         bad_count = 0;
   int         checks_done = 0;

   csie_ctrl #(.SE0_CYC_P(20), .T128_CYC_P(8), .T1024_CYC_P(16), .WDOG_CYC_P(50), .STARTUP_CYC_P(80)) i_dut (.*);

   // ==========================================================
   // Clock and access tasks.
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : cyc

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask : pulse

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      io_addr_i = a;
      io_wdata_i = d;
      pulse(port_write_instr_i);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      io_addr_i = a;
      io_read_i = 1'b1;
      cyc(1);
      rd = io_rdata_o;
      io_read_i = 1'b0;
      chk(rd & m, e);
      cyc(1);
   endtask : rc

   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk({7'h0, s}, {7'h0, v});
   endtask : wait_for

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   initial
   begin
      #100000;
      bad_count++;
      close_out();
   end

   // ==========================================================
   // Test sequence.
   initial
   begin
      {port_write_instr_i, io_read_i, halt_instr_i, enable_irq_instr_i, disable_irq_instr_i} = '0;
      {return_from_irq_instr_i, irq_enter_i, watchdog_clear_i, usb_dm_i, usb_activity_i} = '0;
      {endpoint_irq_i, serial_irq_i, gpio_irq_i, hub_irq_i, io_addr_i, io_wdata_i} = '0;
      usb_dp_i = 1'b1;
      reset_i = 1'b1;
      cyc(5);
      reset_i = 1'b0;
      cyc(2);
      wait_for(cpu_run_o, 1'b1);
      rc(ADDR_PROC_STATE_CTRL, 8'h7F, 8'h51);
      watchdog_clear_i = 1'b1;
      rc(ADDR_GLOBAL_IRQ_MASK, 8'hFF, 8'h00);
      rc(ADDR_ENDPOINT_IRQ_MASK, 8'hFF, 8'h00);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'hFF);
      rc(ADDR_GLOBAL_IRQ_MASK, 8'hFF, 8'h6F);
      wr(ADDR_ENDPOINT_IRQ_MASK, 8'hFF);
      rc(ADDR_ENDPOINT_IRQ_MASK, 8'hFF, 8'h1F);
      rc(8'h22, 8'hFF, 8'h00);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'h00);
      wr(ADDR_ENDPOINT_IRQ_MASK, 8'h00);
      wr(ADDR_PROC_STATE_CTRL, 8'h05);
      rc(ADDR_PROC_STATE_CTRL, 8'h04, 8'h00);
      pulse(enable_irq_instr_i);
      rc(ADDR_PROC_STATE_CTRL, 8'h04, 8'h04);
      pulse(disable_irq_instr_i);
      rc(ADDR_PROC_STATE_CTRL, 8'h04, 8'h00);
      pulse(return_from_irq_instr_i);
      rc(ADDR_PROC_STATE_CTRL, 8'h04, 8'h04);
      wr(ADDR_PROC_STATE_CTRL, 8'h31);
      rc(ADDR_PROC_STATE_CTRL, 8'h7B, 8'h31);
      watchdog_clear_i = 1'b0;
      wait_for(watchdog_reset_flag_o, 1'b1);
      watchdog_clear_i = 1'b1;
      rc(ADDR_PROC_STATE_CTRL, 8'h7F, 8'h71);
      pulse(enable_irq_instr_i);
      for (int k = 0; k < 8; k++)
      begin
         {endpoint_irq_i, serial_irq_i, gpio_irq_i, hub_irq_i} = 8'h01 << k;
         cyc(1);
         {endpoint_irq_i, serial_irq_i, gpio_irq_i, hub_irq_i} = 8'h00;
         cyc(3);
         chk({7'h0, irq_pending_o}, 8'h00);
         if (k < 3)
            wr(ADDR_GLOBAL_IRQ_MASK, (k == 0) ? 8'h08 : (k == 1) ? 8'h20 : 8'h40);
         else
            wr(ADDR_ENDPOINT_IRQ_MASK, 8'(8'h01 << (k - 3)));
         cyc(2);
         chk({irq_pending_o, 3'h0, irq_vector_o}, {4'h8, 4'(k + 3)});
         pulse(irq_enter_i);
         cyc(2);
         chk({4'h0, irq_vector_o}, 8'h0F);
         wr(ADDR_GLOBAL_IRQ_MASK, 8'h00);
         wr(ADDR_ENDPOINT_IRQ_MASK, 8'h00);
         pulse(enable_irq_instr_i);
      end
      for (int j = 1; j < 3; j++)
      begin
         wr(ADDR_GLOBAL_IRQ_MASK, 8'(8'h01 << j));
         wait_for(irq_pending_o, 1'b1);
         chk({4'h0, irq_vector_o}, 8'(j));
         pulse(irq_enter_i);
         pulse(enable_irq_instr_i);
      end
      wr(ADDR_PROC_STATE_CTRL, 8'h01);
      {usb_dp_i, usb_dm_i} = 2'h1;
      cyc(30);
      {usb_dp_i, usb_dm_i} = 2'h2;
      cyc(5);
      rc(ADDR_PROC_STATE_CTRL, 8'h20, 8'h00);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'h01);
      usb_dp_i = 1'b0;
      cyc(30);
      chk({7'h0, irq_pending_o}, 8'h00);
      usb_dp_i = 1'b1;
      wait_for(irq_pending_o, 1'b1);
      chk({4'h0, irq_vector_o}, 8'h00);
      rc(ADDR_PROC_STATE_CTRL, 8'h20, 8'h20);
      pulse(irq_enter_i);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'h00);
      usb_activity_i = 1'b1;
      cyc(5);
      wr(ADDR_PROC_STATE_CTRL, 8'h09);
      cyc(4);
      chk({7'h0, suspended_o}, 8'h00);
      usb_activity_i = 1'b0;
      cyc(5);
      wr(ADDR_PROC_STATE_CTRL, 8'h09);
      cyc(4);
      chk({6'h0, suspended_o, cpu_run_o}, 8'h02);
      usb_activity_i = 1'b1;
      wait_for(suspended_o, 1'b0);
      cyc(8);
      usb_activity_i = 1'b0;
      cyc(3);
      chk({7'h0, cpu_run_o}, 8'h01);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'h08);
      pulse(enable_irq_instr_i);
      wr(ADDR_PROC_STATE_CTRL, 8'h09);
      cyc(4);
      chk({7'h0, suspended_o}, 8'h01);
      pulse(hub_irq_i);
      wait_for(suspended_o, 1'b0);
      pulse(irq_enter_i);
      wr(ADDR_GLOBAL_IRQ_MASK, 8'h00);
      pulse(halt_instr_i);
      rc(ADDR_PROC_STATE_CTRL, 8'h7F, 8'h00);
      pulse(enable_irq_instr_i);
      wr(ADDR_PROC_STATE_CTRL, 8'h01);
      cyc(10);
      chk({7'h0, cpu_run_o}, 8'h00);
      watchdog_clear_i = 1'b0;
      wait_for(cpu_run_o, 1'b1);
      rc(ADDR_PROC_STATE_CTRL, 8'h7F, 8'h41);
      reset_i = 1'b1;
      usb_dp_i = 1'b0;
      cyc(5);
      reset_i = 1'b0;
      rc(ADDR_PROC_STATE_CTRL, 8'h70, 8'h10);
      cyc(30);
      usb_dp_i = 1'b1;
      wait_for(cpu_run_o, 1'b1);
      watchdog_clear_i = 1'b1;
      rc(ADDR_PROC_STATE_CTRL, 8'h5F, 8'h11);
      close_out();
   end
endmodule : csie_ctrl_bench
